// ==== rtl/ivm_pkg.sv ====
// constants for the interrupt vector map and flag bookkeeping block
// assumes a single 40 MHz system clock and an active-low asynchronous reset
package ivm_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// source counts and field widths
	localparam int          NSRC       = 118;        // user sources, vectors 8..125
	localparam int          PRIO_W     = 3;          // eight priority levels
	localparam int          VEC_W      = 7;          // pending vector number width
	localparam int          LVL_W      = 4;          // pending level width
	localparam int          ADDR_W     = 24;         // program address width
	localparam int          NTRAP      = 5;          // processor trap sources
	localparam int          CTRL_W     = 16;         // global control register width

	////////////////////////////////////////////////////////////////////////////////
	// vector numbers and table addresses
	localparam logic [6:0]  USER_VEC_BASE = 7'h08;   // first user vector
	localparam logic [6:0]  TRAP_VEC_BASE = 7'h01;   // oscillator failure vector
	localparam logic [23:0] PRIMARY_BASE  = 24'h000004; // vector 0 slot, primary table
	localparam logic [23:0] ALT_OFFSET    = 24'h000100; // alternate table displacement
	localparam logic [23:0] CODE_START    = 24'h000200; // first word after both tables

	////////////////////////////////////////////////////////////////////////////////
	// natural-order positions of the three external pins
	localparam int          EXT0_POS   = 0;          // vector 8
	localparam int          EXT1_POS   = 20;         // vector 28
	localparam int          EXT2_POS   = 29;         // vector 37

	////////////////////////////////////////////////////////////////////////////////
	// first global control register fields
	localparam int          C1_NEST_OFF = 15;        // nesting disable
	localparam int          C1_OSC      = 1;         // oscillator failure status
	localparam int          C1_STK      = 2;         // stack error status
	localparam int          C1_ADDR     = 3;         // address error status
	localparam int          C1_MATH     = 4;         // math error status
	localparam int          C1_DMA      = 5;         // dma error status
	localparam logic [15:0] C1_WMASK    = 16'hfffe;  // bit 0 unimplemented
	localparam logic [15:0] C1_RESET    = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// second global control register fields
	localparam int          C2_ALT_SEL  = 15;        // alternate table select
	localparam logic [15:0] C2_WMASK    = 16'h8007;  // select bit and three polarities
	localparam logic [15:0] C2_RESET    = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// fixed levels presented for traps, above every user level
	localparam logic [3:0]  TRAP_LVL_TOP = 4'he;     // oscillator failure, falling by vector

	// mask of natural-order positions that have a connected source
	function automatic logic [NSRC-1:0] conn_mask();
		logic [NSRC-1:0] m;
		m = '0;
		for (int i = 0; i <= 14; i++) m[i] = 1'b1;   // vectors 8..22
		for (int i = 16; i <= 20; i++) m[i] = 1'b1;  // vectors 24..28
		for (int i = 22; i <= 36; i++) m[i] = 1'b1;  // vectors 30..44
		for (int i = 45; i <= 46; i++) m[i] = 1'b1;  // vectors 53..54
		for (int i = 59; i <= 62; i++) m[i] = 1'b1;  // vectors 67..70
		for (int i = 65; i <= 70; i++) m[i] = 1'b1;  // vectors 73..78
		for (int i = 78; i <= 79; i++) m[i] = 1'b1;  // vectors 86..87
		return m;
	endfunction

	localparam logic [NSRC-1:0] CONNECTED = conn_mask();

	// table address of a vector in either table
	function automatic logic [23:0] vec_addr(input logic [6:0] vec, input logic alt);
		logic [23:0] a;
		a = PRIMARY_BASE + {16'h0000, vec, 1'b0};
		return alt ? a + ALT_OFFSET : a;
	endfunction

endpackage

// ==== rtl/ivm_arbiter.sv ====
// priority arbiter over the active user sources
// assumes active already combines flag, enable and connection
module ivm_arbiter (
	input  wire logic [ivm_pkg::NSRC-1:0]                active_i,   // flag and enable both set
	input  wire logic [ivm_pkg::NSRC*ivm_pkg::PRIO_W-1:0] prio_i,     // packed priority fields
	output logic                                         valid_o,    // some source nonzero level
	output logic [6:0]                                   index_o,    // winning natural order
	output logic [ivm_pkg::PRIO_W-1:0]                   level_o     // winning priority
);

	////////////////////////////////////////////////////////////////////////////////
	// scan from the highest index down so lower natural order wins ties
	always_comb begin
		logic [ivm_pkg::PRIO_W-1:0] p;
		p       = '0;
		valid_o = 1'b0;
		index_o = 7'h00;
		level_o = '0;
		for (int i = ivm_pkg::NSRC - 1; i >= 0; i--) begin
			p = prio_i[i*ivm_pkg::PRIO_W +: ivm_pkg::PRIO_W];
			if (active_i[i] && p != '0 && p >= level_o) begin
				valid_o = 1'b1;
				index_o = 7'(i);
				level_o = p;
			end
		end
	end

endmodule // ivm_arbiter

// ==== rtl/ivm_core.sv ====
// interrupt vector map: request flags, trap status, vector selection
// assumes all inputs synchronous to CLK_SYS_I; software writes arrive as strobes

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - thirty registers: controls, flag/enable/priority banks, pending
// - first control: nesting disable plus trap flags
// - second control: pin edge polarity, alternate select
// - hardware sets flag, software write clears it
// - one enable bit per source
// - three-bit priority per user source
// - latch pending vector number and level
// - bits allocated in vector order from vector 8
// - vectors one to five are the traps
// - alternate table offset 0x100 words
// - vectors 8 to 16 fixed sources
// - vectors 17 to 22 and 24 to 28 fixed sources
// - vectors 30 to 44 fixed sources
// - vectors 53-54, 67-70, 73-78 and 86-87 fixed sources
// - alternate select redirects every vector fetch
// - lower vector wins natural priority
module ivm_core (
	input  wire logic                                  CLK_SYS_I,        // 40 MHz system clock
	input  wire logic                                  RESETN_I,         // async reset, active low
	input  wire logic [ivm_pkg::NSRC-1:0]              SRC_EVT_I,        // peripheral request pulses
	input  wire logic [2:0]                            EXT_PIN_I,        // external request pins
	input  wire logic [ivm_pkg::NTRAP-1:0]             TRAP_EVT_I,       // trap events, vectors 1..5
	input  wire logic [ivm_pkg::NSRC-1:0]              FLAG_CLR_I,       // software clear strobes
	input  wire logic [ivm_pkg::NSRC-1:0]              ENABLE_I,         // enable bank contents
	input  wire logic [ivm_pkg::NSRC*ivm_pkg::PRIO_W-1:0] PRIORITY_I,    // priority bank contents
	input  wire logic                                  CTRL1_WR_I,       // first control write
	input  wire logic [ivm_pkg::CTRL_W-1:0]            CTRL1_WDATA_I,    // first control data
	input  wire logic                                  CTRL2_WR_I,       // second control write
	input  wire logic [ivm_pkg::CTRL_W-1:0]            CTRL2_WDATA_I,    // second control data
	input  wire logic [ivm_pkg::LVL_W-1:0]             CPU_LEVEL_I,      // current cpu level
	input  wire logic                                  CPU_IN_SERVICE_I, // cpu inside a handler
	output logic      [ivm_pkg::NSRC-1:0]              FLAG_O,           // request flag bank
	output logic      [ivm_pkg::CTRL_W-1:0]            CTRL1_O,          // first control readback
	output logic      [ivm_pkg::CTRL_W-1:0]            CTRL2_O,          // second control readback
	output logic                                       IRQ_REQ_O,        // vector pending to cpu
	output logic      [ivm_pkg::VEC_W-1:0]             VEC_NUM_O,        // pending vector number
	output logic      [ivm_pkg::LVL_W-1:0]             LEVEL_O,          // pending level
	output logic      [ivm_pkg::ADDR_W-1:0]            VEC_ADDR_O        // table slot to fetch
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	logic [ivm_pkg::NSRC-1:0]   flag_q, flag_d;        // request flags
	logic [ivm_pkg::CTRL_W-1:0] ctrl1_q, ctrl1_d;      // first global control
	logic [ivm_pkg::CTRL_W-1:0] ctrl2_q, ctrl2_d;      // second global control
	logic [2:0]                 pin_q, pin_d;          // previous pin levels
	logic                       req_q, req_d;          // pending valid
	logic [ivm_pkg::VEC_W-1:0]  vec_q, vec_d;          // pending vector
	logic [ivm_pkg::LVL_W-1:0]  lvl_q, lvl_d;          // pending level
	logic [ivm_pkg::ADDR_W-1:0] addr_q, addr_d;        // fetch address

	////////////////////////////////////////////////////////////////////////////////
	// combinational helpers
	logic [2:0]                 ext_edge;              // polarity-qualified pin edges
	logic [ivm_pkg::NSRC-1:0]   set_vec;               // flag set requests
	logic [ivm_pkg::NSRC-1:0]   active;                // flag and enable
	logic                       arb_valid;             // arbiter found a source
	logic [6:0]                 arb_index;             // winning natural order
	logic [ivm_pkg::PRIO_W-1:0] arb_level;             // winning priority
	logic [ivm_pkg::NTRAP-1:0]  trap_flags;            // trap status in vector order

	// trap flags ordered by vector 1..5
	assign trap_flags = {ctrl1_q[ivm_pkg::C1_DMA], ctrl1_q[ivm_pkg::C1_MATH],
	                     ctrl1_q[ivm_pkg::C1_STK], ctrl1_q[ivm_pkg::C1_ADDR],
	                     ctrl1_q[ivm_pkg::C1_OSC]};

	////////////////////////////////////////////////////////////////////////////////
	// external pin edge detect and flag set/clear
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			// polarity bit set means falling edge
			ext_edge[k] = ctrl2_q[k] ? (pin_q[k] & ~EXT_PIN_I[k])
			                         : (~pin_q[k] & EXT_PIN_I[k]);
		end
		set_vec = SRC_EVT_I;
		set_vec[ivm_pkg::EXT0_POS] = ext_edge[0];
		set_vec[ivm_pkg::EXT1_POS] = ext_edge[1];
		set_vec[ivm_pkg::EXT2_POS] = ext_edge[2];
		pin_d  = EXT_PIN_I;
		// set wins over a clear in the same cycle
		flag_d = (flag_q & ~FLAG_CLR_I) | (set_vec & ivm_pkg::CONNECTED);
		active = flag_q & ENABLE_I & ivm_pkg::CONNECTED;
	end

	////////////////////////////////////////////////////////////////////////////////
	// global control registers
	always_comb begin
		ctrl1_d = ctrl1_q;
		if (CTRL1_WR_I) begin
			ctrl1_d = CTRL1_WDATA_I & ivm_pkg::C1_WMASK;
		end
		// trap events set status after the write so they are not lost
		ctrl1_d[ivm_pkg::C1_OSC]  = ctrl1_d[ivm_pkg::C1_OSC]  | TRAP_EVT_I[0];
		ctrl1_d[ivm_pkg::C1_ADDR] = ctrl1_d[ivm_pkg::C1_ADDR] | TRAP_EVT_I[1];
		ctrl1_d[ivm_pkg::C1_STK]  = ctrl1_d[ivm_pkg::C1_STK]  | TRAP_EVT_I[2];
		ctrl1_d[ivm_pkg::C1_MATH] = ctrl1_d[ivm_pkg::C1_MATH] | TRAP_EVT_I[3];
		ctrl1_d[ivm_pkg::C1_DMA]  = ctrl1_d[ivm_pkg::C1_DMA]  | TRAP_EVT_I[4];
		ctrl2_d = CTRL2_WR_I ? (CTRL2_WDATA_I & ivm_pkg::C2_WMASK) : ctrl2_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// user source arbitration
	ivm_arbiter u_arb (
		.active_i (active),
		.prio_i   (PRIORITY_I),
		.valid_o  (arb_valid),
		.index_o  (arb_index),
		.level_o  (arb_level)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pending vector selection: traps first, then user sources
	always_comb begin
		logic user_ok;
		user_ok = arb_valid && ({1'b0, arb_level} > CPU_LEVEL_I)
		          && !(ctrl1_q[ivm_pkg::C1_NEST_OFF] && CPU_IN_SERVICE_I);
		req_d = 1'b0;
		vec_d = vec_q;
		lvl_d = lvl_q;
		// lowest trap vector wins, highest index scanned first
		for (int t = ivm_pkg::NTRAP - 1; t >= 0; t--) begin
			if (trap_flags[t]) begin
				req_d = 1'b1;
				vec_d = ivm_pkg::TRAP_VEC_BASE + 7'(t);
				lvl_d = ivm_pkg::TRAP_LVL_TOP - 4'(t);
			end
		end
		if (!req_d && user_ok) begin
			req_d = 1'b1;
			vec_d = ivm_pkg::USER_VEC_BASE + arb_index;
			lvl_d = {1'b0, arb_level};
		end
		addr_d = ivm_pkg::vec_addr(vec_d, ctrl2_q[ivm_pkg::C2_ALT_SEL]);
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			flag_q  <= '0;
			ctrl1_q <= ivm_pkg::C1_RESET;
			ctrl2_q <= ivm_pkg::C2_RESET;
			pin_q   <= 3'h0;
			req_q   <= 1'b0;
			vec_q   <= 7'h00;
			lvl_q   <= 4'h0;
			addr_q  <= 24'h000000;
		end else begin
			flag_q  <= flag_d;
			ctrl1_q <= ctrl1_d;
			ctrl2_q <= ctrl2_d;
			pin_q   <= pin_d;
			req_q   <= req_d;
			vec_q   <= vec_d;
			lvl_q   <= lvl_d;
			addr_q  <= addr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flip-flops
	assign FLAG_O     = flag_q;
	assign CTRL1_O    = ctrl1_q;
	assign CTRL2_O    = ctrl2_q;
	assign IRQ_REQ_O  = req_q;
	assign VEC_NUM_O  = vec_q;
	assign LEVEL_O    = lvl_q;
	assign VEC_ADDR_O = addr_q;

endmodule // ivm_core

// ==== sim/ivm_core_checker.sv ====
// port assertions for the vector map block
// assumes one clock domain; attached to every ivm_core by bind
module ivm_core_checker (
	input wire logic                    CLK_SYS_I,
	input wire logic                    RESETN_I,
	input wire logic [117:0]            SRC_EVT_I,
	input wire logic [4:0]              TRAP_EVT_I,
	input wire logic [117:0]            FLAG_CLR_I,
	input wire logic [117:0]            ENABLE_I,
	input wire logic [353:0]            PRIORITY_I,
	input wire logic                    CTRL2_WR_I,
	input wire logic [15:0]             CTRL2_WDATA_I,
	input wire logic [3:0]              CPU_LEVEL_I,
	input wire logic                    CPU_IN_SERVICE_I,
	input wire logic [117:0]            FLAG_O,
	input wire logic [15:0]             CTRL1_O,
	input wire logic [15:0]             CTRL2_O,
	input wire logic                    IRQ_REQ_O,
	input wire logic [6:0]              VEC_NUM_O,
	input wire logic [3:0]              LEVEL_O,
	input wire logic [23:0]             VEC_ADDR_O
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RESETN_I);
	////////////////////////////////////////////////////////////////////////////////
	flag_set_a: assert property (SRC_EVT_I[3] |=> FLAG_O[3])
		else $error("request flag not set");
	flag_hold_a: assert property (FLAG_O[3] && !FLAG_CLR_I[3] |=> FLAG_O[3])
		else $error("request flag lost");
	flag_clr_a: assert property (FLAG_CLR_I[3] && !SRC_EVT_I[3] |=> !FLAG_O[3])
		else $error("request flag not cleared");
	reserved_quiet_a: assert property ((FLAG_O & ~ivm_pkg::CONNECTED) == '0)
		else $error("reserved flag set");
	vec_range_a: assert property (IRQ_REQ_O |-> VEC_NUM_O inside {[1:5], [8:87]})
		else $error("reserved vector pending");
	addr_map_a: assert property (IRQ_REQ_O && $stable(CTRL2_O) |->
		VEC_ADDR_O == 24'h4 + {VEC_NUM_O, 1'b0} + (CTRL2_O[15] ? 24'h100 : 24'h0))
		else $error("vector address wrong");
	trap_level_a: assert property (IRQ_REQ_O && VEC_NUM_O < 7'h6 |->
		LEVEL_O == 4'hf - {1'b0, VEC_NUM_O[2:0]}) else $error("trap level wrong");
	user_above_a: assert property (IRQ_REQ_O && VEC_NUM_O > 7'h7 |->
		LEVEL_O > $past(CPU_LEVEL_I)) else $error("user level not above cpu");
	irq_due_a: assert property (FLAG_O[3] && ENABLE_I[3] &&
		{1'b0, PRIORITY_I[11:9]} > CPU_LEVEL_I && !(CTRL1_O[15] && CPU_IN_SERVICE_I)
		|=> IRQ_REQ_O) else $error("request not presented");
	trap_flag_a: assert property (TRAP_EVT_I[2] |=> CTRL1_O[2])
		else $error("trap status not set");
	ctrl2_wr_a: assert property (CTRL2_WR_I |=>
		CTRL2_O == ($past(CTRL2_WDATA_I) & 16'h8007))
		else $error("second control write wrong");
	user_irq_c: cover property (IRQ_REQ_O && VEC_NUM_O == 7'h0b);
	alt_irq_c: cover property (IRQ_REQ_O && CTRL2_O[15]);
	trap_irq_c: cover property (IRQ_REQ_O && VEC_NUM_O == 7'h03);
endmodule // ivm_core_checker

bind ivm_core ivm_core_checker chk (.*);

// ==== sim/ivm_periph_model.sv ====
// peripheral request lines feeding the vector map
// assumes requests are one-cycle pulses launched just after an edge
module ivm_periph_model (
	input  wire logic         clk_i,  // system clock
	input  wire logic         fire_i, // launch a pulse next cycle
	input  wire logic [117:0] sel_i,  // lines to pulse
	output logic      [117:0] evt_o   // request pulses
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle low, one cycle high per request; unknown only until the first edge
	always @(posedge clk_i) evt_o <= #1 fire_i ? sel_i : '0;
endmodule // ivm_periph_model

// ==== sim/interrupt_vector_and_flag_map_tb.sv ====
// self-checking bench for the vector map block
// assumes ivm_core, its checker and the peripheral model are compiled first
module interrupt_vector_and_flag_map_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic         clk = 0, rst_n = 0, c1wr = 0, c2wr = 0, insvc = 0, fire = 0, alt = 0, pirq, irq;
	logic [117:0] clr = '0, en = '0, sel = '0, evt, flag;
	logic [353:0] prio = '0;
	logic [2:0]   ext = '0, pol = '0;
	logic [4:0]   trap = '0;
	logic [15:0]  c1d = '0, c2d = '0, c1, c2;
	logic [3:0]   lvl = '0, vlvl;
	logic [6:0]   vnum, pvec;
	logic [23:0]  vaddr;
	logic [34:0]  expq[$], e;
	int           mismatches = 0, tests_run = 0, seed = 49;
	int           rsv[4] = '{15, 21, 37, 117};
	always #12.5 clk = ~clk;
	ivm_periph_model src (.clk_i(clk), .fire_i(fire), .sel_i(sel), .evt_o(evt));
	ivm_core dut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .SRC_EVT_I(evt), .EXT_PIN_I(ext),
		.TRAP_EVT_I(trap), .FLAG_CLR_I(clr), .ENABLE_I(en), .PRIORITY_I(prio),
		.CTRL1_WR_I(c1wr), .CTRL1_WDATA_I(c1d), .CTRL2_WR_I(c2wr), .CTRL2_WDATA_I(c2d),
		.CPU_LEVEL_I(lvl), .CPU_IN_SERVICE_I(insvc), .FLAG_O(flag), .CTRL1_O(c1),
		.CTRL2_O(c2), .IRQ_REQ_O(irq), .VEC_NUM_O(vnum), .LEVEL_O(vlvl), .VEC_ADDR_O(vaddr));
	////////////////////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// wide enough for the whole flag bank plus both control words
	task automatic chk(input string nm, input logic [159:0] seen, input logic [159:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// expected vector, level and table slot
	task automatic note(input int v, input int l);
		expq.push_back({7'(v), 4'(l), 24'(4 + 2 * v + (alt ? 256 : 0))});
	endtask
	task automatic wait_irq(input logic v);
		for (int k = 0; k < 20 && irq !== v; k++) step(1);
		chk("irq", irq, v);
	endtask
	task automatic drop(input int p);
		clr[p] = 1'b1;
		step(1);
		clr[p] = 1'b0;
	endtask
	task automatic wr1(input logic [15:0] d);
		c1d = d;
		c1wr = 1'b1;
		step(1);
		c1wr = 1'b0;
		step(1);
		chk("ctrl1", c1, d & 16'hfffe);
	endtask
	task automatic wr2(input logic [15:0] d);
		c2d = d;
		c2wr = 1'b1;
		step(1);
		c2wr = 1'b0;
		step(1);
		chk("ctrl2", c2, d & 16'h8007);
		alt = d[15];
		pol = d[2:0];
		ext = d[2:0];
		step(2);
	endtask
	// pins get their active edge, others a model pulse
	task automatic hit(input int p);
		int k;
		k = (p == 0) ? 0 : (p == 20) ? 1 : 2;
		if (p == 0 || p == 20 || p == 29) begin
			ext[k] = ~pol[k];
			step(1);
			ext[k] = pol[k];
		end else begin
			sel = '0;
			sel[p] = 1'b1;
			fire = 1'b1;
			step(1);
			fire = 1'b0;
		end
	endtask
	task automatic svc(input int p, input logic [2:0] pr);
		en[p] = 1'b1;
		prio[3*p +: 3] = pr;
		note(p + 8, pr);
		hit(p);
		wait_irq(1);
		drop(p);
		wait_irq(0);
		en[p] = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// compares each new pending vector with the oldest note
	// sampled on the falling edge so the registered outputs have settled
	always @(negedge clk) begin
		if (irq === 1'b1 && (pirq !== 1'b1 || vnum !== pvec)) begin
			e = expq.size() ? expq.pop_front() : '1;
			chk("vector", vnum, e[34:28]);
			chk("level", vlvl, e[27:24]);
			chk("address", vaddr, e[23:0]);
		end
		pirq = irq;
		pvec = vnum;
	end
	initial begin
		#(25 * 20000);
		mismatches++;
		summarize();
	end
	initial begin
		step(20);
		rst_n = 1'b1;
		step(1);
		chk("reset", {flag, c1, c2, irq}, 0);
		for (int p = 0; p < 118; p++) begin
			if (p % 10 == 0) wr2(16'($random(seed)));
			if (ivm_pkg::CONNECTED[p]) svc(p, 3'(1 + $unsigned($random(seed)) % 7));
		end
		foreach (rsv[i]) begin
			en[rsv[i]] = 1'b1;
			prio[3*rsv[i] +: 3] = 3'h7;
			hit(rsv[i]);
			step(3);
			chk("reserved", {flag[rsv[i]], irq}, 0);
			en = '0;
		end
		en[5] = 1'b1;
		prio[17:15] = 3'h3;
		lvl = 4'h3;
		hit(5);
		step(4);
		chk("irq at level", irq, 0);
		note(13, 3);
		lvl = 4'h2;
		wait_irq(1);
		drop(5);
		wait_irq(0);
		lvl = 4'h0;
		wr1(16'h8000);
		insvc = 1'b1;
		en[6] = 1'b1;
		prio[20:18] = 3'h7;
		hit(6);
		step(4);
		chk("irq nested", irq, 0);
		note(14, 7);
		insvc = 1'b0;
		wait_irq(1);
		drop(6);
		wait_irq(0);
		wr1(16'h0000);
		en = '0;
		en[2] = 1'b1;
		en[5] = 1'b1;
		prio[8:6] = 3'h3;
		note(10, 3);
		note(13, 3);
		sel = '0;
		sel[2] = 1'b1;
		sel[5] = 1'b1;
		fire = 1'b1;
		step(1);
		fire = 1'b0;
		wait_irq(1);
		drop(2);
		step(3);
		drop(5);
		wait_irq(0);
		en = '0;
		en[3] = 1'b1;
		prio[11:9] = 3'h7;
		note(11, 7);
		hit(3);
		wait_irq(1);
		note(3, 12);
		trap[2] = 1'b1;
		step(1);
		trap = '0;
		step(3);
		chk("stack status", c1[2], 1);
		note(11, 7);
		wr1(16'h0000);
		step(3);
		drop(3);
		wait_irq(0);
		// every noted vector must have been presented
		chk("notes left", expq.size(), 0);
		summarize();
	end
endmodule // interrupt_vector_and_flag_map_tb
